/* dsdd_mac_sink.sv */
// Behavioural model of the MAC side that collects the serial receive bits.
`timescale 1ns/1ns
module dsdd_mac_sink (
  input wire logic sys_clk,
  input wire logic rx_data,
  input wire logic rx_data_valid
);
  logic bits[$];
  // The port carries no framing, so arrival order is the only record of the stream.
  always @(posedge sys_clk) begin
    if (rx_data_valid === 1'b1) begin
      bits.push_back(rx_data);
    end
  end
endmodule : dsdd_mac_sink

/* dsdd_params.svh */
// Register offsets, field positions, reset values and counts for the receive decoder.
`ifndef DSDD_PARAMS_SVH
`define DSDD_PARAMS_SVH
`define DSDD_ADDR_POLARITY    8'h02
`define DSDD_ADDR_RX_INIT     8'h04
`define DSDD_ADDR_LOCKED_CLK  8'h0C
`define DSDD_ADDR_EQUALIZER   8'h14
`define DSDD_ADDR_TRACK_OPT   8'h42
`define DSDD_ADDR_STATUS      8'h70
`define DSDD_ADDR_TIMING      8'h72
`define DSDD_POL_RX_BIT       7
`define DSDD_POL_TX_BIT       6
`define DSDD_INIT_BIT         0
`define DSDD_LOCKED_CLK_BIT   2
`define DSDD_SERVICE_LOCK_BIT 2
`define DSDD_EQ_ICI_OFF_BIT   4
`define DSDD_EQ_ISI_OFF_BIT   5
`define DSDD_TRACK_LO_BIT     6
`define DSDD_REG_RST          8'h00
`define DSDD_INIT_RST         8'h01
`define DSDD_TIMING_LIMIT     8'sh48
`define DSDD_SEED_SYMBOLS     3'h7
`define DSDD_LAST_IDX_11M     6'h3F
`define DSDD_LAST_IDX_5M5     6'h03
`define DSDD_BITS_11M         4'h8
`define DSDD_BITS_5M5         4'h4
`define DSDD_EQ_SHIFT         7
`define DSDD_LO_STEP_SHIFT    4
`endif

/* dsdd_pkg.sv */
// Types shared by the receive decoder: data rates and controller states.
package dsdd_pkg;
  typedef enum logic [1:0] {
    rate_1m   = 2'h0,
    rate_2m   = 2'h1,
    rate_5m5  = 2'h2,
    rate_11m  = 2'h3
  } dsdd_rate_type;
  typedef enum logic [2:0] {
    st_idle   = 3'h1,
    st_track  = 3'h2,
    st_search = 3'h4
  } dsdd_state_type;
endpackage : dsdd_pkg

/* dsdd_rx_core.sv */
// Receive data recovery: derotation, CCK picker, equalizer, decoder and descrambler.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`include "dsdd_params.svh"
module dsdd_rx_core
  import dsdd_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_write_data,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output      logic [7:0]        reg_read_data,
  input  wire logic              acq_locked,
  input  wire logic [1:0]        rate_select,
  input  wire logic              header_last_bit,
  input  wire logic              psk_valid,
  input  wire logic signed [7:0] psk_i,
  input  wire logic signed [7:0] psk_q,
  input  wire logic              sample_valid,
  input  wire logic signed [7:0] sample_i,
  input  wire logic signed [7:0] sample_q,
  input  wire logic              symbol_strobe,
  input  wire logic              train_valid,
  input  wire logic              service_valid,
  input  wire logic [7:0]        service_field,
  input  wire logic              timing_early,
  input  wire logic              timing_late,
  output      logic              rx_data,
  output      logic              rx_data_valid,
  output      logic signed [7:0] timing_offset
);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic signed [9:0] dsdd_eq_term(input logic signed [7:0]  coef,
                                                     input logic signed [12:0] x);
    logic signed [20:0] prod;
    prod = 21'(coef) * 21'(x);
    return 10'(prod >>> `DSDD_EQ_SHIFT);
  endfunction : dsdd_eq_term

  // Each code is a sign pattern over eight chips; the index picks the pattern.
  function automatic logic signed [12:0] dsdd_correlate(input logic [5:0]  idx,
                                                        input logic [79:0] vec);
    logic signed [12:0] acc;
    logic signed [9:0]  x;
    logic               flip;
    acc = 13'sh0000;
    for (int n = 0; n < 8; n++) begin
      x    = $signed(vec[n*10 +: 10]);
      flip = (^(idx[2:0] & 3'(n))) ^ (idx[5:3] == 3'(n));
      acc  = flip ? acc - 13'(x) : acc + 13'(x);
    end
    return acc;
  endfunction : dsdd_correlate

  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0]         io_polarity_config;
  logic [7:0]         rx_init_config;
  logic [7:0]         locked_clock_config;
  logic [7:0]         equalizer_control;
  logic [7:0]         tracking_option_control;
  dsdd_state_type     state;
  logic               run;
  logic               seeded;
  logic               lo_mode;
  logic               service_locked;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      io_polarity_config      <= `DSDD_REG_RST;
      rx_init_config          <= `DSDD_INIT_RST;
      locked_clock_config     <= `DSDD_REG_RST;
      equalizer_control       <= `DSDD_REG_RST;
      tracking_option_control <= `DSDD_REG_RST;
    end else if (reg_write) begin
      case (reg_addr)
        `DSDD_ADDR_POLARITY:   io_polarity_config      <= reg_write_data;
        `DSDD_ADDR_RX_INIT:    rx_init_config          <= reg_write_data;
        `DSDD_ADDR_LOCKED_CLK: locked_clock_config     <= reg_write_data;
        `DSDD_ADDR_EQUALIZER:  equalizer_control       <= reg_write_data;
        `DSDD_ADDR_TRACK_OPT:  tracking_option_control <= reg_write_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_read_data <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `DSDD_ADDR_POLARITY:   reg_read_data <= io_polarity_config;
        `DSDD_ADDR_RX_INIT:    reg_read_data <= rx_init_config;
        `DSDD_ADDR_LOCKED_CLK: reg_read_data <= locked_clock_config;
        `DSDD_ADDR_EQUALIZER:  reg_read_data <= equalizer_control;
        `DSDD_ADDR_TRACK_OPT:  reg_read_data <= tracking_option_control;
        `DSDD_ADDR_STATUS:     reg_read_data <= {3'h0, service_locked, lo_mode, seeded,
                                                 state == st_search, state != st_idle};
        `DSDD_ADDR_TIMING:     reg_read_data <= timing_offset;
        default:               reg_read_data <= 8'h00;
      endcase
    end else begin
      reg_read_data <= 8'h00;
    end
  end

  // Soft initialisation holds all learned tracking state cleared, except the equalizer coefficient eq_coef.
  assign run = acq_locked & ~rx_init_config[`DSDD_INIT_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  logic signed [8:0]  q_in;
  logic signed [8:0]  rot_i;
  logic signed [8:0]  rot_q;
  logic signed [9:0]  cost_err;
  logic signed [8:0]  cost_a;
  logic signed [8:0]  cost_b;
  logic [15:0]        nco_phase;
  logic signed [19:0] loop_integ;
  logic               prev_sign_i;
  logic               decim_phase;
  logic               chip_take;
  logic               cost_update;

  always_comb begin
    q_in = io_polarity_config[`DSDD_POL_RX_BIT] ? -9'(sample_q) : 9'(sample_q);
    case (nco_phase[15:14])
      2'h1:    begin rot_i = -q_in;         rot_q = 9'(sample_i);  end
      2'h2:    begin rot_i = -9'(sample_i); rot_q = -q_in;         end
      2'h3:    begin rot_i = q_in;          rot_q = -9'(sample_i); end
      default: begin rot_i = 9'(sample_i);  rot_q = q_in;          end
    endcase
    cost_a   = rot_i[8] ? -rot_q : rot_q;
    cost_b   = rot_q[8] ? -rot_i : rot_i;
    cost_err = 10'(cost_a) - 10'(cost_b);
  end

  assign chip_take   = run & sample_valid & decim_phase;
  assign cost_update = chip_take & (rot_i[8] != prev_sign_i);

  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      decim_phase <= 1'b0;
      prev_sign_i <= 1'b0;
      nco_phase   <= 16'h0000;
      loop_integ  <= 20'sh00000;
    end else begin
      if (sample_valid) begin
        decim_phase <= ~decim_phase;
      end
      if (chip_take) begin
        prev_sign_i <= rot_i[8];
      end
      if (cost_update) begin
        loop_integ <= loop_integ + 20'(cost_err);
      end
      nco_phase <= nco_phase + 16'(loop_integ >>> 4) +
                   (cost_update ? (16'(cost_err) <<< 2) : 16'h0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic signed [7:0]  eq_coef;
  logic signed [9:0]  isi_residual;
  logic signed [8:0]  prev_chip_i;
  logic signed [8:0]  prev_chip_q;
  logic               ici_on;
  logic               isi_on;
  logic [2:0]         chip_idx;
  logic signed [9:0]  chip_in_i;
  logic signed [9:0]  chip_in_q;
  logic signed [9:0]  isi_cut;
  logic [79:0]        chip_vec_i;
  logic [79:0]        chip_vec_q;

  assign ici_on = ~equalizer_control[`DSDD_EQ_ICI_OFF_BIT];
  assign isi_on = ~equalizer_control[`DSDD_EQ_ISI_OFF_BIT];

  always_comb begin
    isi_cut   = (isi_on && chip_idx == 3'h0) ? isi_residual : 10'sh000;
    chip_in_i = 10'(rot_i) - isi_cut -
                (ici_on ? dsdd_eq_term(eq_coef, 13'(prev_chip_i)) : 10'sh000);
    chip_in_q = 10'(rot_q) -
                (ici_on ? dsdd_eq_term(eq_coef, 13'(prev_chip_q)) : 10'sh000);
  end

  // Training runs only while no CCK packet is in progress, so the
  // coefficient stays fixed from the header onward.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      eq_coef <= 8'sh00;
    end else if (train_valid && state == st_idle) begin
      eq_coef <= eq_coef + 8'((9'(sample_i) - 9'(eq_coef)) >>> 2);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      prev_chip_i <= 9'sh000;
      prev_chip_q <= 9'sh000;
      chip_idx    <= 3'h0;
      chip_vec_i  <= 80'h0;
      chip_vec_q  <= 80'h0;
    end else if (chip_take) begin
      prev_chip_i <= rot_i;
      prev_chip_q <= rot_q;
      chip_idx    <= symbol_strobe ? 3'h0 : chip_idx + 3'h1;
      chip_vec_i  <= {chip_vec_i[69:0], chip_in_i};
      chip_vec_q  <= {chip_vec_q[69:0], chip_in_q};
    end else if (symbol_strobe) begin
      chip_idx <= 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic [79:0]        batch_i;
  logic [79:0]        batch_q;
  logic [5:0]         search_idx;
  logic [5:0]         last_idx;
  logic [5:0]         best_idx;
  logic               best_q;
  logic [12:0]        best_mag;
  logic signed [12:0] best_val;
  logic signed [12:0] corr_i;
  logic signed [12:0] corr_q;
  logic [12:0]        mag_i;
  logic [12:0]        mag_q;
  logic               cur_q;
  logic [12:0]        cur_mag;
  logic               take_cur;
  logic [5:0]         fin_idx;
  logic               fin_q;
  logic signed [12:0] fin_val;
  logic               phase_bit;
  logic               ref_sign;
  logic               decide;
  logic               is_cck;

  assign is_cck   = rate_select[1];
  assign last_idx = (rate_select == rate_11m) ? `DSDD_LAST_IDX_11M : `DSDD_LAST_IDX_5M5;
  assign decide   = (state == st_search) && (search_idx == last_idx);

  always_comb begin
    corr_i    = dsdd_correlate(search_idx, batch_i);
    corr_q    = dsdd_correlate(search_idx, batch_q);
    mag_i     = corr_i[12] ? 13'(-corr_i) : 13'(corr_i);
    mag_q     = corr_q[12] ? 13'(-corr_q) : 13'(corr_q);
    cur_q     = mag_q > mag_i;
    cur_mag   = cur_q ? mag_q : mag_i;
    take_cur  = (search_idx == 6'h00) || (cur_mag > best_mag);
    fin_idx   = take_cur ? search_idx : best_idx;
    fin_q     = take_cur ? cur_q : best_q;
    fin_val   = take_cur ? (cur_q ? corr_q : corr_i) : best_val;
    phase_bit = fin_val[12] ^ ref_sign;
  end

  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle:   if (header_last_bit && is_cck) state <= st_track;
        st_track:  if (symbol_strobe) state <= st_search;
        st_search: if (decide) state <= st_track;
        default:   state <= st_idle;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      batch_i      <= 80'h0;
      batch_q      <= 80'h0;
      search_idx   <= 6'h00;
      best_idx     <= 6'h00;
      best_q       <= 1'b0;
      best_mag     <= 13'h0000;
      best_val     <= 13'sh0000;
      ref_sign     <= 1'b0;
      isi_residual <= 10'sh000;
    end else begin
      if (header_last_bit) begin
        ref_sign <= psk_i[7];
      end
      if (state == st_track && symbol_strobe) begin
        batch_i    <= chip_vec_i;
        batch_q    <= chip_vec_q;
        search_idx <= 6'h00;
      end else if (state == st_search) begin
        search_idx <= search_idx + 6'h01;
        best_idx   <= fin_idx;
        best_q     <= fin_q;
        best_mag   <= fin_val[12] ? 13'(-fin_val) : 13'(fin_val);
        best_val   <= fin_val;
        if (decide) begin
          ref_sign     <= fin_val[12];
          isi_residual <= dsdd_eq_term(eq_coef, fin_val);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0]         quad_now;
  logic [1:0]         quad_prev;
  logic [1:0]         quad_diff;
  logic signed [7:0]  psk_q_pol;
  logic [7:0]         out_queue;
  logic [3:0]         out_count;
  logic               psk_take;

  assign psk_take  = run & psk_valid & ~is_cck;
  assign psk_q_pol = io_polarity_config[`DSDD_POL_RX_BIT] ? -psk_q : psk_q;

  always_comb begin
    case ({psk_i[7], psk_q_pol[7]})
      2'b00:   quad_now = 2'h0;
      2'b10:   quad_now = 2'h1;
      2'b11:   quad_now = 2'h2;
      default: quad_now = 2'h3;
    endcase
    quad_diff = quad_now - quad_prev;
  end

  // The queue shifts out LSB first, so the earliest bit sits in bit 0.
  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      quad_prev <= 2'h0;
      out_queue <= 8'h00;
      out_count <= 4'h0;
    end else if (decide) begin
      if (rate_select == rate_11m) begin
        out_queue <= {phase_bit, fin_q, fin_idx};
        out_count <= `DSDD_BITS_11M;
      end else begin
        out_queue <= {4'h0, phase_bit, fin_q, fin_idx[1:0]};
        out_count <= `DSDD_BITS_5M5;
      end
    end else if (psk_take) begin
      quad_prev <= quad_now;
      if (rate_select == rate_2m) begin
        case (quad_diff)
          2'h1:    out_queue <= 8'h02;
          2'h2:    out_queue <= 8'h03;
          2'h3:    out_queue <= 8'h01;
          default: out_queue <= 8'h00;
        endcase
        out_count <= 4'h2;
      end else begin
        out_queue <= {7'h00, quad_diff[1]};
        out_count <= 4'h1;
      end
    end else if (out_count != 4'h0) begin
      out_queue <= {1'b0, out_queue[7:1]};
      out_count <= out_count - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic [6:0]         scram_sr;
  logic [2:0]         seed_cnt;
  logic               emit;
  logic               in_bit;
  logic               out_seeded;

  assign emit   = run & (out_count != 4'h0) & ~decide & ~psk_take;
  assign in_bit = out_queue[0];
  assign seeded = (seed_cnt == `DSDD_SEED_SYMBOLS);

  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      seed_cnt   <= 3'h0;
      out_seeded <= 1'b0;
    end else if (decide || psk_take) begin
      // A symbol that arrives while the count is still short is only seed.
      out_seeded <= seeded;
      if (!seeded) begin
        seed_cnt <= seed_cnt + 3'h1;
      end
    end
  end

  // Taps at delays four and seven; the register holds received bits, which
  // makes the circuit self-synchronising after seven bits.
  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      scram_sr      <= 7'h00;
      rx_data       <= 1'b0;
      rx_data_valid <= 1'b0;
    end else begin
      rx_data_valid <= emit & out_seeded;
      if (emit) begin
        rx_data  <= in_bit ^ scram_sr[3] ^ scram_sr[6];
        scram_sr <= {scram_sr[5:0], in_bit};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic [16:0]        lo_acc;
  logic [15:0]        lo_mag;
  logic               lo_step;
  logic               step_up;
  logic               step_dn;

  assign lo_mode = service_locked & locked_clock_config[`DSDD_LOCKED_CLK_BIT] &
                   tracking_option_control[`DSDD_TRACK_LO_BIT];
  assign lo_mag  = loop_integ[19] ? 16'((-loop_integ) >>> `DSDD_LO_STEP_SHIFT)
                                  : 16'(loop_integ >>> `DSDD_LO_STEP_SHIFT);
  assign lo_step = lo_acc[16];
  assign step_up = lo_mode ? (lo_step & ~loop_integ[19]) : (timing_late & ~timing_early);
  assign step_dn = lo_mode ? (lo_step & loop_integ[19]) : (timing_early & ~timing_late);

  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      service_locked <= 1'b0;
    end else if (service_valid) begin
      service_locked <= service_field[`DSDD_SERVICE_LOCK_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      lo_acc        <= 17'h00000;
      timing_offset <= 8'sh00;
    end else begin
      lo_acc <= 17'(lo_acc[15:0]) + 17'(lo_mag);
      if (step_up && timing_offset != `DSDD_TIMING_LIMIT) begin
        timing_offset <= timing_offset + 8'sh01;
      end else if (step_dn && timing_offset != -`DSDD_TIMING_LIMIT) begin
        timing_offset <= timing_offset - 8'sh01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_timing_range;
    timing_offset <= `DSDD_TIMING_LIMIT && timing_offset >= -`DSDD_TIMING_LIMIT;
  endproperty
  a_timing_range: assert property (p_timing_range) else $error("timing out of range");

  property p_descramble;
    rx_data_valid |-> rx_data == ($past(in_bit) ^ $past(scram_sr[3]) ^ $past(scram_sr[6]));
  endproperty
  a_descramble: assert property (p_descramble) else $error("descrambler output wrong");

  property p_seed;
    rx_data_valid |-> $past(seed_cnt) == `DSDD_SEED_SYMBOLS;
  endproperty
  a_seed: assert property (p_seed) else $error("output before seeding");

  property p_dqpsk;
    psk_take && !decide && rate_select == rate_2m && quad_diff == 2'h2
      |=> out_count == 4'h2 && out_queue[1:0] == 2'h3;
  endproperty
  a_dqpsk: assert property (p_dqpsk) else $error("dqpsk 180 map wrong");

  property p_coef_frozen;
    state != st_idle |=> $stable(eq_coef);
  endproperty
  a_coef_frozen: assert property (p_coef_frozen) else $error("coefficient changed");

  property p_search_5m5;
    run && state == st_track && symbol_strobe && rate_select == rate_5m5 && $stable(rate_select)
      ##1 (run && $stable(rate_select)) [*4] |=> state == st_track && $past(state) == st_search;
  endproperty
  a_search_5m5: assert property (p_search_5m5) else $error("5.5 search length");

  property p_cck_bits;
    decide && rate_select == rate_11m |=> out_count == `DSDD_BITS_11M;
  endproperty
  a_cck_bits: assert property (p_cck_bits) else $error("11M symbol bits");

  property p_costas_hold;
    run && !cost_update |=> $stable(loop_integ);
  endproperty
  a_costas_hold: assert property (p_costas_hold) else $error("loop updated");

  property p_ref_capture;
    run && header_last_bit && state == st_idle |=> ref_sign == $past(psk_i[7]);
  endproperty
  a_ref_capture: assert property (p_ref_capture) else $error("reference not captured");

endmodule : dsdd_rx_core

/* testbench.sv */
// Self-checking bench: PSK decode and descramble, registers and interpolator limits.
`timescale 1ns/1ns
`include "dsdd_params.svh"
module testbench;
  import dsdd_pkg::*;
  logic sys_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, acq_locked = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_write_data = 8'h00, reg_read_data, service_field = 8'h00;
  logic [1:0] rate_select = 2'h0;
  logic psk_valid = 1'b0, train_valid = 1'b0, timing_early = 1'b0, timing_late = 1'b0;
  logic header_last_bit = 1'b0, sample_valid = 1'b0, symbol_strobe = 1'b0, service_valid = 1'b0;
  logic signed [7:0] psk_i = 8'sh00, psk_q = 8'sh00, sample_i = 8'sh00, sample_q = 8'sh00;
  logic signed [7:0] timing_offset;
  logic rx_data, rx_data_valid;
  integer seed = 25973, failures = 0, cmp_count = 0;
  logic [7:0] rd;
  always #50 sys_clk = ~sys_clk;
  dsdd_rx_core dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_write_data(reg_write_data), .reg_write(reg_write), .reg_read(reg_read),
    .reg_read_data(reg_read_data), .acq_locked(acq_locked), .rate_select(rate_select),
    .header_last_bit(header_last_bit), .psk_valid(psk_valid), .psk_i(psk_i), .psk_q(psk_q),
    .sample_valid(sample_valid), .sample_i(sample_i), .sample_q(sample_q),
    .symbol_strobe(symbol_strobe), .train_valid(train_valid),
    .service_valid(service_valid), .service_field(service_field),
    .timing_early(timing_early), .timing_late(timing_late), .rx_data(rx_data),
    .rx_data_valid(rx_data_valid), .timing_offset(timing_offset));
  dsdd_mac_sink mac (.sys_clk(sys_clk), .rx_data(rx_data), .rx_data_valid(rx_data_valid));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_write_data <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    d = reg_read_data;
  endtask : reg_rd
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////////
  // Reference model: quadrant difference, dibit map, then x^7+x^4+1 self-sync division.
  task automatic run_psk(input string name, input logic [1:0] rate, input bit inv, input int n);
    logic [6:0] sr;
    logic [1:0] q, prev, d;
    logic b[$];
    logic exp[$];
    @(posedge sys_clk);
    acq_locked <= 1'b0;
    rate_select <= rate;
    repeat (3) @(posedge sys_clk);
    mac.bits.delete();
    sr = 7'h00;
    prev = 2'h0;
    acq_locked <= 1'b1;
    for (int k = 0; k < n; k++) begin
      q = (k == 0) ? 2'h0 : 2'($random(seed));
      if (rate == 2'h0) q = {q[0], 1'b0};
      d = q - prev;
      prev = q;
      b.delete();
      if (rate == 2'h0) b.push_back(d == 2'h2);
      else begin
        b.push_back(d[1]);
        b.push_back(d[1] ^ d[0]);
      end
      foreach (b[j]) begin
        if (k >= 7) exp.push_back(b[j] ^ sr[3] ^ sr[6]);
        sr = {sr[5:0], b[j]};
      end
      @(posedge sys_clk);
      psk_valid <= 1'b1;
      psk_i <= (q == 2'h0 || q == 2'h3) ? 8'sh3C : -8'sh3C;
      psk_q <= ((q < 2'h2) ^ inv) ? 8'sh3C : -8'sh3C;
      train_valid <= 1'($random(seed));
      sample_i <= 8'($random(seed));
      @(posedge sys_clk);
      psk_valid <= 1'b0;
      repeat (5) @(posedge sys_clk);
    end
    check("bit count", 8'(mac.bits.size()), 8'(exp.size()));
    foreach (exp[j]) begin
      check("rx bit", {7'h00, mac.bits[j]}, {7'h00, exp[j]});
    end
    $display("test %s done", name);
  endtask : run_psk
  // CCK symbols carry random chips, so only the bit count per symbol is predicted.
  task automatic run_cck(input string name, input logic [1:0] rate, input int n);
    int gap;
    int per;
    gap = (rate == 2'h3) ? 76 : 12;
    per = (rate == 2'h3) ? 8 : 4;
    @(posedge sys_clk);
    acq_locked <= 1'b0;
    rate_select <= rate;
    repeat (3) @(posedge sys_clk);
    mac.bits.delete();
    acq_locked <= 1'b1;
    psk_i <= 8'shC4;
    header_last_bit <= 1'b1;
    @(posedge sys_clk);
    header_last_bit <= 1'b0;
    reg_rd(`DSDD_ADDR_STATUS, rd);
    check("cck start", rd, 8'h01);
    for (int k = 0; k < n * gap; k++) begin
      @(posedge sys_clk);
      symbol_strobe <= (k % gap == 0);
      sample_valid <= 1'($random(seed));
      train_valid <= 1'($random(seed));
      sample_i <= 8'($random(seed));
      sample_q <= 8'($random(seed));
    end
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check("cck bit count", 8'(mac.bits.size()), 8'((n - 7) * per));
    reg_rd(`DSDD_ADDR_STATUS, rd);
    check("cck seeded", rd, 8'h05);
    $display("test %s done", name);
  endtask : run_cck
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    reg_rd(`DSDD_ADDR_RX_INIT, rd);
    check("init reset", rd, 8'h01);
    reg_rd(`DSDD_ADDR_POLARITY, rd);
    check("polarity reset", rd, 8'h00);
    reg_wr(8'h10, 8'hFF);
    reg_rd(8'h10, rd);
    check("unmapped", rd, 8'h00);
    reg_wr(`DSDD_ADDR_RX_INIT, 8'h00);
    $display("test registers done");
    run_psk("dbpsk", 2'h0, 1'b0, 30);
    run_psk("dqpsk", 2'h1, 1'b0, 30);
    reg_rd(`DSDD_ADDR_STATUS, rd);
    check("status", rd, 8'h04);
    reg_wr(`DSDD_ADDR_POLARITY, 8'h80);
    reg_rd(`DSDD_ADDR_POLARITY, rd);
    check("polarity", rd, 8'h80);
    run_psk("dqpsk inverted", 2'h1, 1'b1, 30);
    run_cck("cck 5.5", 2'h2, 9);
    run_cck("cck 11", 2'h3, 9);
    @(posedge sys_clk);
    timing_late <= 1'b1;
    repeat (80) @(posedge sys_clk);
    timing_late <= 1'b0;
    reg_rd(`DSDD_ADDR_TIMING, rd);
    check("offset max", rd, 8'h48);
    @(posedge sys_clk);
    timing_early <= 1'b1;
    repeat (160) @(posedge sys_clk);
    timing_early <= 1'b0;
    @(negedge sys_clk);
    check("offset min", timing_offset, 8'hB8);
    $display("test timing done");
    // Relocking clears the loop integrator, so locked-oscillator steps stay idle.
    @(posedge sys_clk);
    acq_locked <= 1'b0;
    reg_wr(`DSDD_ADDR_LOCKED_CLK, 8'h04);
    reg_wr(`DSDD_ADDR_TRACK_OPT, 8'h40);
    acq_locked <= 1'b1;
    service_field <= 8'h04;
    service_valid <= 1'b1;
    @(posedge sys_clk);
    service_valid <= 1'b0;
    reg_rd(`DSDD_ADDR_STATUS, rd);
    check("lo status", rd, 8'h18);
    @(posedge sys_clk);
    timing_late <= 1'b1;
    repeat (10) @(posedge sys_clk);
    timing_late <= 1'b0;
    @(negedge sys_clk);
    check("lo ignores late", timing_offset, 8'h00);
    reg_wr(`DSDD_ADDR_TRACK_OPT, 8'h00);
    timing_late <= 1'b1;
    repeat (10) @(posedge sys_clk);
    timing_late <= 1'b0;
    @(negedge sys_clk);
    check("lo disabled", timing_offset, 8'h0A);
    $display("test locked oscillator done");
    stop_test();
  end
endmodule : testbench
